// file: logic/dls_pkg.sv
package dls_pkg;
  // ****************************************************************
  // link geometry
  // ****************************************************************
  localparam int DLS_LANES         = 4;
  localparam int DLS_BITS_PER_LANE = 7;
  localparam int DLS_WORD_W        = DLS_LANES * DLS_BITS_PER_LANE;
  localparam int DLS_SLOT_W        = 3;
  localparam logic [DLS_SLOT_W-1:0] DLS_SLOT_FIRST = 3'h0;
  localparam logic [DLS_SLOT_W-1:0] DLS_SLOT_LAST  = 3'h6;
  // forwarded clock is high in slots below this one
  localparam logic [DLS_SLOT_W-1:0] DLS_CLK_HI_SLOTS = 3'h4;

  // ****************************************************************
  // buffering and timing
  // ****************************************************************
  localparam int DLS_BUF_DEPTH   = 2;
  localparam int DLS_CNT_W       = 2;
  localparam logic [DLS_CNT_W-1:0] DLS_BUF_FULL = 2'h2;
  localparam logic [DLS_CNT_W-1:0] DLS_BUF_NONE = 2'h0;
  localparam int DLS_CLK_MHZ     = 50;
  // slowest legal parallel clock, and the missing-clock timeout
  localparam int DLS_PAR_MIN_MHZ = 20;
  localparam int DLS_IDLE_CYCLES = 64;
  localparam int DLS_FREE_HALF   = 16;
  localparam int DLS_TMR_W       = 16;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [DLS_WORD_W-1:0] dls_word_t;

  typedef struct packed {
    logic                 par_clk;
    logic                 edge_sel;
    logic                 sleep_n;
    logic                 fwd_clk;
    logic [DLS_LANES-1:0] lanes;
    dls_word_t            data;
  } dls_pins_t;

  typedef struct packed {
    logic [DLS_LANES-1:0] lane;
    logic                 clk;
  } dls_link_t;

  typedef enum {DLS_PLL_LOCKED, DLS_PLL_FREE} dls_pll_t;
endpackage : dls_pkg

// file: logic/dls_display_link_serdes.sv
`timescale 1ns/1ps
// Notes on behaviour
// - capture whole word each parallel clock, four lanes
// - each lane carries seven bits per word
// - parallel clock stays within legal frequency range
// - default capture edge is rising
// - edge select picks rising or falling capture
// - sleep floats all serial lane and forwarded clock outputs
// - missing clock drops to low free-running rate
// - receiver rebuilds word from lanes and clock
// - receiver sleep drives all data outputs high
// - sleep or dead link holds clock output low
module dls_display_link_serdes
  import dls_pkg::*;
#(
  parameter int ACTIVE_LANES = DLS_LANES,
  parameter int IDLE_CYCLES  = DLS_IDLE_CYCLES,
  parameter int FREE_HALF    = DLS_FREE_HALF
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 par_clk_in,
  input  wire dls_word_t            par_data_in,
  input  wire logic                 strobe_edge_sel,
  input  wire logic                 sleep_n,
  output logic                      par_in_ready,
  output logic [DLS_LANES-1:0]      serial_lane_out,
  output logic [DLS_LANES-1:0]      serial_lane_oe,
  output logic                      fwd_clk_out,
  output logic                      fwd_clk_oe,
  input  wire logic [DLS_LANES-1:0] serial_lane_in,
  input  wire logic                 fwd_clk_in,
  output dls_word_t                 par_data_out,
  output logic                      recovered_clk_out
);
  localparam logic [DLS_TMR_W-1:0] IDLE_LIM = DLS_TMR_W'(IDLE_CYCLES);
  localparam logic [DLS_TMR_W-1:0] HALF_LIM = DLS_TMR_W'(FREE_HALF - 1);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  dls_pins_t pins_raw, s1_r, s2_r;
  logic      pclk_d_r, rclk_d_r;
  assign pins_raw = '{par_clk: par_clk_in, edge_sel: strobe_edge_sel,
                      sleep_n: sleep_n, fwd_clk: fwd_clk_in,
                      lanes: serial_lane_in, data: par_data_in};
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r     <= '0;
      s2_r     <= '0;
      pclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end else begin
      s1_r     <= pins_raw;
      s2_r     <= s1_r;
      pclk_d_r <= s2_r.par_clk;
      rclk_d_r <= s2_r.fwd_clk;
    end
  end

  logic awake, cap_edge, rx_edge;
  assign awake    = s2_r.sleep_n;
  assign cap_edge = s2_r.edge_sel ? (s2_r.par_clk & ~pclk_d_r)
                                  : (~s2_r.par_clk & pclk_d_r);
  assign rx_edge  = s2_r.fwd_clk & ~rclk_d_r;

  // ****************************************************************
  // two-entry capture buffer
  // ****************************************************************
  dls_word_t            buf_mem_r [DLS_BUF_DEPTH];
  logic                 wr_ptr_r, rd_ptr_r;
  logic [DLS_CNT_W-1:0] cnt_r;
  logic                 push, pop, busy_r;
  logic [DLS_SLOT_W-1:0] slot_r;
  dls_word_t            word_r;

  assign par_in_ready = (cnt_r != DLS_BUF_FULL);
  assign push = cap_edge & awake & par_in_ready;
  assign pop  = awake & (cnt_r != DLS_BUF_NONE)
              & (~busy_r | (slot_r == DLS_SLOT_LAST));

  always_ff @(posedge clk) begin
    if (rst || !awake) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= DLS_BUF_NONE;
    end else begin
      if (push) begin
        buf_mem_r[wr_ptr_r] <= s2_r.data;
        wr_ptr_r            <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      cnt_r <= DLS_CNT_W'(cnt_r + DLS_CNT_W'(push) - DLS_CNT_W'(pop));
    end
  end

  // ****************************************************************
  // serializer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst || !awake) begin
      busy_r <= 1'b0;
      slot_r <= DLS_SLOT_FIRST;
      word_r <= '0;
    end else if (pop) begin
      busy_r <= 1'b1;
      slot_r <= DLS_SLOT_FIRST;
      word_r <= buf_mem_r[rd_ptr_r];
    end else if (busy_r && slot_r == DLS_SLOT_LAST) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      slot_r <= slot_r + 3'h1;
    end
  end

  // free-running fallback when the parallel clock stops
  dls_pll_t             pll_r;
  logic [DLS_TMR_W-1:0] idle_r, div_r;
  logic                 free_clk_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_r  <= DLS_PLL_LOCKED;
      idle_r <= '0;
    end else if (cap_edge) begin
      pll_r  <= DLS_PLL_LOCKED;
      idle_r <= '0;
    end else if (idle_r == IDLE_LIM) begin
      pll_r  <= DLS_PLL_FREE;
    end else begin
      idle_r <= idle_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || pll_r == DLS_PLL_LOCKED) begin
      div_r      <= '0;
      free_clk_r <= 1'b0;
    end else if (div_r == HALF_LIM) begin
      div_r      <= '0;
      free_clk_r <= ~free_clk_r;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  dls_link_t                 link_r;
  wire logic [DLS_LANES-1:0] lane_nxt;
  genvar gl;
  // per-lane bit select is combinational so one process owns link_r
  generate
    for (gl = 0; gl < DLS_LANES; gl++) begin : g_tx_lane
      assign lane_nxt[gl] = (gl < ACTIVE_LANES) && busy_r
        && word_r[gl*DLS_BITS_PER_LANE + int'(slot_r)];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst || !awake) begin
      link_r <= '0;
    end else begin
      link_r.lane <= lane_nxt;
      if (pll_r == DLS_PLL_FREE) begin
        link_r.clk <= free_clk_r;
      end else begin
        link_r.clk <= busy_r & (slot_r < DLS_CLK_HI_SLOTS);
      end
    end
  end

  assign serial_lane_out = link_r.lane;
  assign fwd_clk_out     = link_r.clk;
  assign serial_lane_oe  = {DLS_LANES{awake}};
  assign fwd_clk_oe      = awake;

  // ****************************************************************
  // deserializer
  // ****************************************************************
  logic                  rx_busy_r, rx_done_r, rx_dead_r;
  logic [DLS_SLOT_W-1:0] rx_slot_r, rx_slot;
  logic [DLS_TMR_W-1:0]  rx_idle_r;
  wire dls_word_t        rx_acc;
  logic                  rx_take;
  assign rx_take = awake & (rx_edge | rx_busy_r);
  assign rx_slot = rx_edge ? DLS_SLOT_FIRST : rx_slot_r;

  always_ff @(posedge clk) begin
    if (rst || !awake) begin
      rx_busy_r <= 1'b0;
      rx_slot_r <= DLS_SLOT_FIRST;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= rx_take & (rx_slot == DLS_SLOT_LAST);
      rx_busy_r <= rx_take & (rx_slot != DLS_SLOT_LAST);
      rx_slot_r <= rx_take ? rx_slot + 3'h1 : DLS_SLOT_FIRST;
    end
  end

  generate
    for (gl = 0; gl < DLS_LANES; gl++) begin : g_rx_lane
      // each lane owns its slice, so no two processes share a variable
      logic [DLS_BITS_PER_LANE-1:0] acc_r;
      always_ff @(posedge clk) begin
        if (rst) begin
          acc_r <= '0;
        end else if (rx_take && gl < ACTIVE_LANES) begin
          acc_r[rx_slot] <= s2_r.lanes[gl];
        end
      end
      assign rx_acc[gl*DLS_BITS_PER_LANE +: DLS_BITS_PER_LANE] = acc_r;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_idle_r <= '0;
      rx_dead_r <= 1'b1;
    end else if (rx_edge) begin
      rx_idle_r <= '0;
      rx_dead_r <= 1'b0;
    end else if (rx_idle_r == IDLE_LIM) begin
      rx_dead_r <= 1'b1;
    end else begin
      rx_idle_r <= rx_idle_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      par_data_out      <= '0;
      recovered_clk_out <= 1'b0;
    end else if (!awake) begin
      par_data_out      <= '1;
      recovered_clk_out <= 1'b0;
    end else begin
      if (rx_done_r) begin
        par_data_out <= rx_acc;
      end
      recovered_clk_out <= rx_done_r & ~rx_dead_r;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sleep_floats: assert property (!awake |-> (serial_lane_oe == '0)
    && !fwd_clk_oe) else $error("outputs driven in sleep");
  a_sleep_data_hi: assert property (!awake |=> par_data_out == '1)
    else $error("rx data not high in sleep");
  a_sleep_clk_lo: assert property ((!awake || rx_dead_r) |=>
    !recovered_clk_out) else $error("rx clock not low");
  a_seven_slots: assert property ($rose(busy_r) |-> busy_r[*7] ##1
    (!busy_r || $past(pop))) else $error("word not 7 slots");
  a_capture_push: assert property ((cap_edge && awake && par_in_ready)
    |=> cnt_r != DLS_BUF_NONE) else $error("word not captured");
  a_rise_edge: assert property ((s2_r.edge_sel && $rose(s2_r.par_clk)
    && !$past(s2_r.par_clk, 2)) |-> cap_edge)
    else $error("rising capture missed");
  a_fall_edge: assert property ((!s2_r.edge_sel && $fell(s2_r.par_clk))
    |-> cap_edge) else $error("falling capture missed");
  a_free_run: assert property ((awake && pll_r == DLS_PLL_FREE) |=>
    fwd_clk_out == $past(free_clk_r)) else $error("no free run");
  a_clk_aligned: assert property ((awake && pll_r == DLS_PLL_LOCKED
    && pop) |=> ##1 fwd_clk_out) else $error("clock not aligned");
  a_rx_word: assert property ((awake && rx_done_r) |=>
    par_data_out == $past(rx_acc)) else $error("rx word lost");
  a_buf_bound: assert property (cnt_r <= DLS_BUF_FULL)
    else $error("buffer overrun");

  c_full_buf: cover property (cnt_r == DLS_BUF_FULL);
  c_free_run: cover property (pll_r == DLS_PLL_FREE ##1 cap_edge);
  c_rx_word:  cover property (recovered_clk_out);
  c_fall_cap: cover property (!s2_r.edge_sel && push);
endmodule : dls_display_link_serdes

// file: dv/dls_panel_model.sv
`timescale 1ns/1ps
module dls_panel_model
  import dls_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [DLS_LANES-1:0] lane_in,
  input  wire logic [DLS_LANES-1:0] lane_oe,
  input  wire logic                 clk_in,
  input  wire logic                 clk_oe,
  output logic [DLS_LANES-1:0]      lane_out,
  output logic                      clk_out
);
  dls_word_t acc_r;
  dls_word_t words_q[$];
  int        slot_r = 7;
  logic      prev_r = 1'b0;
  initial begin
    lane_out = '0;
    clk_out  = 1'b0;
  end
  // ****************************************************************
  // decode of the serial side
  // ****************************************************************
  always @(posedge clk) begin
    prev_r <= clk_in && clk_oe;
    if (clk_oe && clk_in && !prev_r) slot_r = 0;
    if (lane_oe !== 4'hF) slot_r = 7;
    if (slot_r < DLS_BITS_PER_LANE) begin
      for (int l = 0; l < DLS_LANES; l++) acc_r[l*7+slot_r] = lane_in[l];
      if (slot_r == 6) words_q.push_back(acc_r);
      slot_r++;
    end
  end
  // ****************************************************************
  // drive of the serial side, 160 ns per word
  // ****************************************************************
  task automatic send(input dls_word_t w);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      #1;
      // filler slot inverts lanes so stale values are not mistaken
      for (int l = 0; l < DLS_LANES; l++)
        lane_out[l] = (s < 7) ? w[l*7+s] : ~lane_out[l];
      clk_out = (s < 4);
    end
  endtask : send
endmodule : dls_panel_model

// file: dv/dls_display_link_serdes_test.sv
`timescale 1ns/1ps
module dls_display_link_serdes_test;
  import dls_pkg::*;
  logic                 clk = 0, rst = 1, par_clk_in = 0;
  logic                 strobe_edge_sel = 1, sleep_n = 1;
  dls_word_t            par_data_in = '0;
  logic                 par_in_ready, fwd_clk_out, fwd_clk_oe;
  logic                 fwd_clk_in, recovered_clk_out;
  logic [DLS_LANES-1:0] serial_lane_out, serial_lane_oe, serial_lane_in;
  dls_word_t            par_data_out;
  int                   num_errors = 0;
  int                   samples_checked = 0;
  always #10 clk = ~clk;

  dls_display_link_serdes #(.IDLE_CYCLES(16), .FREE_HALF(2)) dut_u (
    .clk(clk), .rst(rst), .par_clk_in(par_clk_in),
    .par_data_in(par_data_in), .strobe_edge_sel(strobe_edge_sel),
    .sleep_n(sleep_n), .par_in_ready(par_in_ready),
    .serial_lane_out(serial_lane_out), .serial_lane_oe(serial_lane_oe),
    .fwd_clk_out(fwd_clk_out), .fwd_clk_oe(fwd_clk_oe),
    .serial_lane_in(serial_lane_in), .fwd_clk_in(fwd_clk_in),
    .par_data_out(par_data_out), .recovered_clk_out(recovered_clk_out));

  dls_panel_model panel_u (
    .clk(clk), .lane_in(serial_lane_out), .lane_oe(serial_lane_oe),
    .clk_in(fwd_clk_out), .clk_oe(fwd_clk_oe),
    .lane_out(serial_lane_in), .clk_out(fwd_clk_in));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input dls_word_t got, input dls_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic par_cycle(input dls_word_t w);
    par_data_in = w;
    par_clk_in  = ~strobe_edge_sel;
    cyc(4);
    par_clk_in  = strobe_edge_sel;
    cyc(4);
  endtask : par_cycle

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_tx(input logic sel);
    dls_word_t exp[3] = '{28'hA5C3F01, 28'h5A3C0FE, 28'hFFFFFFF};
    strobe_edge_sel = sel;
    par_clk_in = ~sel;
    cyc(6);
    panel_u.words_q.delete();
    foreach (exp[i]) par_cycle(exp[i]);
    cyc(20);
    check(dls_word_t'(panel_u.words_q.size()), 28'h3);
    check(dls_word_t'(par_in_ready), 28'h1);
    foreach (exp[i])
      if (panel_u.words_q.size() > i) check(panel_u.words_q[i], exp[i]);
    $display("test tx edge=%0d done", sel);
  endtask : t_tx

  task automatic t_free();
    int   n = 0;
    logic p;
    cyc(24);
    p = fwd_clk_out;
    repeat (16) begin
      cyc(1);
      if (fwd_clk_out !== p) n++;
      p = fwd_clk_out;
    end
    check(dls_word_t'(n), 28'h8);
    check(dls_word_t'(fwd_clk_oe), 28'h1);
    $display("test free run done");
  endtask : t_free

  task automatic t_rx();
    int k = 0;
    panel_u.send(28'h1234567);
    panel_u.send(28'hC3A5F0E);
    while (recovered_clk_out !== 1'b1 && k < 16) begin
      cyc(1);
      k++;
    end
    check(dls_word_t'(recovered_clk_out), 28'h1);
    check(par_data_out, 28'hC3A5F0E);
    cyc(1);
    check(dls_word_t'(recovered_clk_out), 28'h0);
    $display("test rx done");
  endtask : t_rx

  task automatic t_sleep();
    sleep_n = 0;
    cyc(4);
    panel_u.words_q.delete();
    par_cycle(28'h0F0F0F0);
    panel_u.send(28'h0000001);
    cyc(6);
    check(dls_word_t'({serial_lane_oe, fwd_clk_oe}), 28'h0);
    check(dls_word_t'(panel_u.words_q.size()), 28'h0);
    check(par_data_out, 28'hFFFFFFF);
    check(dls_word_t'(recovered_clk_out), 28'h0);
    sleep_n = 1;
    cyc(4);
    $display("test sleep done");
  endtask : t_sleep

  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  initial begin
    cyc(3);
    rst = 0;
    cyc(4);
    t_tx(1'b1);
    t_free();
    t_tx(1'b0);
    t_rx();
    t_sleep();
    final_report();
  end
endmodule : dls_display_link_serdes_test
